// ==== adc_window_pkg.sv ====
// Shared constants, types and helpers for the converter window comparator.
package adc_window_pkg;

  // Special-function addresses of the registers held by the block.
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hbd;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hbe;
  localparam logic [7:0] ADDR_GT_LOW = 8'hc3;
  localparam logic [7:0] ADDR_GT_HIGH = 8'hc4;
  localparam logic [7:0] ADDR_LT_LOW = 8'hc5;
  localparam logic [7:0] ADDR_LT_HIGH = 8'hc6;
  localparam logic [7:0] ADDR_CONTROL = 8'he8;

  // Field positions, reset values and codes.
  localparam int FLAG_BIT = 3;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [4:0] GROUND_SELECT = 5'h1f;
  localparam logic [5:0] LEFT_PAD = 6'h00;

  // A conversion lasts at least this many successive-approximation clocks.
  localparam logic [8:0] CONV_SAR_CLOCKS = 9'h00a;
  localparam logic [8:0] GAP_MAX = 9'h1ff;
  localparam logic [8:0] GAP_ONE = 9'h001;

  typedef struct packed {
    logic [15:0] greaterThan;
    logic [15:0] lessThan;
  } limits_type;

  typedef struct packed {
    logic leftJustify;
    logic differential;
  } mode_type;

  // Places a raw 10-bit code into the 16-bit word the way software reads it.
  function automatic logic [15:0] formatResult(input logic [9:0] raw,
                                               input mode_type mode);
    logic [15:0] word;
    word = 16'h0000;
    if (mode.leftJustify)
      word = {raw, LEFT_PAD};
    else
      word = {{6{mode.differential & raw[9]}}, raw};
    return word;
  endfunction

  // Recovers the ten significant bits of a word and widens them to an
  // 11-bit signed key, so one signed compare covers both number formats.
  function automatic logic signed [10:0] compareKey(input logic [15:0] word,
                                                    input mode_type mode);
    logic [9:0] field;
    field = mode.leftJustify ? word[15:6] : word[9:0];
    return $signed({mode.differential & field[9], field});
  endfunction

  // Minimum spacing of two results in core cycles for a given divider.
  function automatic logic [8:0] minGap(input logic [4:0] sarDivider);
    return 9'(CONV_SAR_CLOCKS * ({4'h0, sarDivider} + 9'h001));
  endfunction

endpackage

// ==== window_compare.sv ====
// Combinational window test of one result word against the two limits.
`timescale 1ns/1ps
module window_compare
(
  input wire adc_window_pkg::limits_type limits,
  input wire adc_window_pkg::mode_type mode,
  input wire logic [15:0] resultWord,
  output logic match
);

  logic signed [10:0] resKey;
  logic signed [10:0] gtKey;
  logic signed [10:0] ltKey;
  logic insideWindow;

  // Keys are formed the same way for all three words.
  assign resKey = adc_window_pkg::compareKey(resultWord, mode);
  assign gtKey = adc_window_pkg::compareKey(limits.greaterThan, mode);
  assign ltKey = adc_window_pkg::compareKey(limits.lessThan, mode);

  // The window sense follows only from the order of the two limits.
  assign insideWindow = gtKey < ltKey;

  // Both senses are strict, so a result on a bound never matches.
  always_comb
  begin
    if (insideWindow)
      match = (resKey > gtKey) && (resKey < ltKey);
    else
      match = (resKey < ltKey) || (resKey > gtKey);
  end

endmodule

// ==== adc_window_comparator.sv ====
// Window comparator for converter results and its special registers.
`timescale 1ns/1ps
module adc_window_comparator
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdData,
  input wire logic convDone,
  input wire logic [9:0] convResult,
  input wire logic leftJustify,
  input wire logic [4:0] negativeInputSelect,
  input wire logic [4:0] sarDivider,
  output logic windowMatchFlag,
  output logic windowIrq
);

  logic [7:0] gtHigh_q;
  logic [7:0] gtLow_q;
  logic [7:0] ltHigh_q;
  logic [7:0] ltLow_q;
  logic [15:0] result_q;
  logic flag_q;
  logic [7:0] rdData_q;
  logic [8:0] sinceLast_q;
  logic convAccept;
  logic cmpMatch;
  logic flagClear;
  logic [15:0] resultNow;
  adc_window_pkg::mode_type mode;
  adc_window_pkg::limits_type limits;

  // Converter settings decide the number format of the comparison.
  assign mode.leftJustify = leftJustify;
  assign mode.differential =
    negativeInputSelect != adc_window_pkg::GROUND_SELECT;
  assign limits.greaterThan = {gtHigh_q, gtLow_q};
  assign limits.lessThan = {ltHigh_q, ltLow_q};
  assign resultNow = adc_window_pkg::formatResult(convResult, mode);

  // A strobe arriving too soon after the last accepted one cannot be a real
  // conversion, so it is dropped rather than compared.
  assign convAccept = convDone &&
    (sinceLast_q >= adc_window_pkg::minGap(sarDivider));
  assign flagClear = sfrWr && (sfrAddr == adc_window_pkg::ADDR_CONTROL) &&
    !sfrWrData[adc_window_pkg::FLAG_BIT];

  window_compare compareUnit
  (
    .limits(limits),
    .mode(mode),
    .resultWord(resultNow),
    .match(cmpMatch)
  );

  // Cycles since the last accepted result; starts saturated after reset.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      sinceLast_q <= adc_window_pkg::GAP_MAX;
    else if (convAccept)
      sinceLast_q <= adc_window_pkg::GAP_ONE;
    else if (sinceLast_q != adc_window_pkg::GAP_MAX)
      sinceLast_q <= sinceLast_q + adc_window_pkg::GAP_ONE;
  end

  // Limit bytes are plain software registers.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      gtHigh_q <= adc_window_pkg::BYTE_RESET;
      gtLow_q <= adc_window_pkg::BYTE_RESET;
      ltHigh_q <= adc_window_pkg::BYTE_RESET;
      ltLow_q <= adc_window_pkg::BYTE_RESET;
    end
    else if (sfrWr)
    begin
      unique case (sfrAddr)
        adc_window_pkg::ADDR_GT_HIGH: gtHigh_q <= sfrWrData;
        adc_window_pkg::ADDR_GT_LOW: gtLow_q <= sfrWrData;
        adc_window_pkg::ADDR_LT_HIGH: ltHigh_q <= sfrWrData;
        adc_window_pkg::ADDR_LT_LOW: ltLow_q <= sfrWrData;
        default: ;
      endcase
    end
  end

  // The formatted result is kept so software can read what was compared.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      result_q <= {adc_window_pkg::BYTE_RESET, adc_window_pkg::BYTE_RESET};
    else if (convAccept)
      result_q <= resultNow;
  end

  // Sticky match flag; a match in the clearing cycle keeps it set.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      flag_q <= 1'b0;
    else if (convAccept && cmpMatch)
      flag_q <= 1'b1;
    else if (flagClear)
      flag_q <= 1'b0;
  end

  // Reads answer one cycle later; unmapped addresses return zero. Only the
  // flag lives in the control byte here, its other bits belong elsewhere.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rdData_q <= adc_window_pkg::READ_ZERO;
    else if (sfrRd)
    begin
      unique case (sfrAddr)
        adc_window_pkg::ADDR_GT_HIGH: rdData_q <= gtHigh_q;
        adc_window_pkg::ADDR_GT_LOW: rdData_q <= gtLow_q;
        adc_window_pkg::ADDR_LT_HIGH: rdData_q <= ltHigh_q;
        adc_window_pkg::ADDR_LT_LOW: rdData_q <= ltLow_q;
        adc_window_pkg::ADDR_RESULT_HIGH: rdData_q <= result_q[15:8];
        adc_window_pkg::ADDR_RESULT_LOW: rdData_q <= result_q[7:0];
        adc_window_pkg::ADDR_CONTROL:
          rdData_q <= 8'(flag_q) << adc_window_pkg::FLAG_BIT;
        default: rdData_q <= adc_window_pkg::READ_ZERO;
      endcase
    end
  end

  // Polled and interrupt views of the same flag flip-flop.
  assign sfrRdData = rdData_q;
  assign windowMatchFlag = flag_q;
  assign windowIrq = flag_q;

  // Independent reference arithmetic for the checks below.
  logic [9:0] refRes;
  logic [9:0] refGt;
  logic [9:0] refLt;
  assign refRes = leftJustify ? resultNow[15:6] : resultNow[9:0];
  assign refGt = leftJustify ? limits.greaterThan[15:6] :
    limits.greaterThan[9:0];
  assign refLt = leftJustify ? limits.lessThan[15:6] : limits.lessThan[9:0];

  property p_match_sets;
    @(posedge core_clk) disable iff (sys_rst)
    convAccept && cmpMatch |=> flag_q ##1 (flag_q || $past(flagClear));
  endproperty
  a_match_sets: assert property (p_match_sets)
    else $error("Accepted match did not set the flag.");

  property p_unsigned_inside;
    @(posedge core_clk) disable iff (sys_rst)
    convAccept && !mode.differential && (refGt < refLt) &&
    (refRes > refGt) && (refRes < refLt) |=> windowMatchFlag;
  endproperty
  a_unsigned_inside: assert property (p_unsigned_inside)
    else $error("Unsigned inside result did not raise the flag.");

  property p_equal_bound;
    @(posedge core_clk) disable iff (sys_rst)
    convAccept && !flag_q && ((refRes == refGt) || (refRes == refLt)) &&
    (refGt != refLt) && !mode.differential |=> !windowMatchFlag;
  endproperty
  a_equal_bound: assert property (p_equal_bound)
    else $error("Result on a bound raised the flag.");

  property p_signed_outside;
    @(posedge core_clk) disable iff (sys_rst)
    convAccept && mode.differential && !($signed(refGt) < $signed(refLt)) &&
    (($signed(refRes) < $signed(refLt)) ||
    ($signed(refRes) > $signed(refGt)))
    |=> windowMatchFlag;
  endproperty
  a_signed_outside: assert property (p_signed_outside)
    else $error("Signed outside result did not raise the flag.");

  property p_signed_inside_miss;
    @(posedge core_clk) disable iff (sys_rst)
    convAccept && !flag_q && mode.differential &&
    ($signed(refGt) < $signed(refLt)) && !($signed(refRes) > $signed(refGt))
    |=> !windowMatchFlag;
  endproperty
  a_signed_inside_miss: assert property (p_signed_inside_miss)
    else $error("Signed result below the window raised the flag.");

  property p_clear_and_hold;
    @(posedge core_clk) disable iff (sys_rst)
    flag_q && !(flagClear && !(convAccept && cmpMatch)) |=> flag_q;
  endproperty
  a_clear_and_hold: assert property (p_clear_and_hold)
    else $error("Flag dropped without a clearing write.");

  property p_clear_works;
    @(posedge core_clk) disable iff (sys_rst)
    flagClear && !convAccept |=> !flag_q;
  endproperty
  a_clear_works: assert property (p_clear_works)
    else $error("Clearing write left the flag set.");

  property p_read_flag;
    @(posedge core_clk) disable iff (sys_rst)
    sfrRd && (sfrAddr == adc_window_pkg::ADDR_CONTROL)
    |=> sfrRdData[adc_window_pkg::FLAG_BIT] == $past(flag_q);
  endproperty
  a_read_flag: assert property (p_read_flag)
    else $error("Control read did not show the flag.");

  property p_reset_limit;
    @(posedge core_clk)
    sys_rst |=> ltLow_q == adc_window_pkg::BYTE_RESET;
  endproperty
  a_reset_limit: assert property (p_reset_limit)
    else $error("Less-than low byte not zero after reset.");

  property p_spacing;
    @(posedge core_clk) disable iff (sys_rst)
    convAccept |=> !convAccept ##1 !convAccept;
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("Two results accepted too close together.");

  property p_left_pad;
    @(posedge core_clk) disable iff (sys_rst)
    convAccept && leftJustify |=> result_q[5:0] == adc_window_pkg::LEFT_PAD;
  endproperty
  a_left_pad: assert property (p_left_pad)
    else $error("Left-justified result has low bits set.");

  c_inside_hit: cover property (@(posedge core_clk) disable iff (sys_rst)
    convAccept && cmpMatch && (refGt < refLt));
  c_outside_hit: cover property (@(posedge core_clk) disable iff (sys_rst)
    convAccept && cmpMatch && mode.differential && !(refGt < refLt));
  c_clear_race: cover property (@(posedge core_clk) disable iff (sys_rst)
    flagClear && convAccept && cmpMatch);
  c_drop_early: cover property (@(posedge core_clk) disable iff (sys_rst)
    convDone && !convAccept);

endmodule

// ==== conv_core_model.sv ====
// Behavioural converter core that hands results to the window comparator.
`timescale 1ns/1ps
module conv_core_model
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic startConv,
  input wire logic hurry,
  input wire logic [9:0] code,
  input wire logic [4:0] sarDivider,
  output logic convDone,
  output logic [9:0] convResult
);
  logic busy_q;
  logic [9:0] count_q;
  logic [9:0] code_q;
  // A conversion lasts ten SAR clocks; hurry cuts it short to test refusal.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      count_q <= 10'h000;
      code_q <= 10'h000;
    end
    else if (startConv)
    begin
      busy_q <= 1'b1;
      count_q <= hurry ? 10'h001 :
        10'(10'h00a * ({5'h00, sarDivider} + 10'h001));
      code_q <= code;
    end
    else if (busy_q)
    begin
      count_q <= count_q - 10'h001;
      busy_q <= (count_q != 10'h001);
    end
  end
  // Result lines toggle outside the strobe, so a stale word cannot pass.
  always_ff @(posedge core_clk)
  begin
    convDone <= !sys_rst && busy_q && !startConv && count_q == 10'h001;
    convResult <= sys_rst ? 10'h000 :
                  (busy_q && count_q == 10'h001) ? code_q : ~convResult;
  end
endmodule

// ==== adc_window_comparator_tb.sv ====
// Self-checking testbench of the converter window comparator.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  errors++; $display("[ERR] t=%0t got %h exp %h", $time, got, exp); end end
module adc_window_comparator_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic [7:0] sfrRdData;
  logic convDone;
  logic [9:0] convResult;
  logic leftJustify = 1'b0;
  logic [4:0] negativeInputSelect = 5'h1f;
  logic [4:0] sarDivider = 5'h01;
  logic windowMatchFlag;
  logic windowIrq;
  logic startConv = 1'b0;
  logic hurry = 1'b0;
  logic [9:0] code = 10'h000;
  int errors = 0;
  int checks_done = 0;
  always #5 core_clk = ~core_clk;
  adc_window_comparator dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrRdData(sfrRdData), .convDone(convDone), .convResult(convResult),
    .leftJustify(leftJustify), .negativeInputSelect(negativeInputSelect),
    .sarDivider(sarDivider), .windowMatchFlag(windowMatchFlag),
    .windowIrq(windowIrq));
  conv_core_model core (.core_clk(core_clk), .sys_rst(sys_rst),
    .startConv(startConv), .hurry(hurry), .code(code),
    .sarDivider(sarDivider), .convDone(convDone), .convResult(convResult));
  // Prints the counts and the verdict, then stops the run.
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One register write; inputs move on the falling edge only.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfrAddr = a;
    sfrWrData = d;
    sfrWr = 1'b1;
    @(negedge core_clk);
    sfrWr = 1'b0;
  endtask
  // One register read; data is valid the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    sfrAddr = a;
    sfrRd = 1'b1;
    @(negedge core_clk);
    sfrRd = 1'b0;
    `CHK(sfrRdData, e)
  endtask
  // Starts a conversion and waits, bounded, for the core to raise the strobe.
  task automatic conv(input logic [9:0] c, input logic h);
    int n;
    @(negedge core_clk);
    code = c;
    hurry = h;
    startConv = 1'b1;
    @(negedge core_clk);
    startConv = 1'b0;
    for (n = 0; n < 500 && convDone !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 500)
    begin
      errors++;
      results();
    end
    @(negedge core_clk);
  endtask
  // Loads both limits, converts one code, checks flag, irq and result bytes.
  task automatic run(input logic [15:0] gt, input logic [15:0] lt,
                     input logic lj, input logic [4:0] neg,
                     input logic [9:0] c, input logic m);
    logic [15:0] w;
    w = lj ? {c, 6'h00} : {{6{(neg != 5'h1f) & c[9]}}, c};
    leftJustify = lj;
    negativeInputSelect = neg;
    wr(8'hc3, gt[7:0]);
    wr(8'hc4, gt[15:8]);
    wr(8'hc5, lt[7:0]);
    wr(8'hc6, lt[15:8]);
    wr(8'he8, 8'h00);
    conv(c, 1'b0);
    `CHK(windowMatchFlag, m)
    `CHK(windowIrq, m)
    rd(8'he8, {4'h0, m, 3'h0});
    rd(8'hbd, w[7:0]);
    rd(8'hbe, w[15:8]);
  endtask
  initial
  begin
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    `CHK(windowMatchFlag, 1'b0)
    rd(8'hc5, 8'h00);
    rd(8'he8, 8'h00);
    wr(8'hc5, 8'ha5);
    rd(8'hc5, 8'ha5);
    rd(8'h00, 8'h00);
    wr(8'hbd, 8'h5a);
    rd(8'hbd, 8'h00);
    run(16'h0040, 16'h0080, 1'b0, 5'h1f, 10'h040, 1'b0);
    run(16'h0040, 16'h0080, 1'b0, 5'h1f, 10'h041, 1'b1);
    run(16'h0040, 16'h0080, 1'b0, 5'h1f, 10'h07f, 1'b1);
    run(16'h0040, 16'h0080, 1'b0, 5'h1f, 10'h080, 1'b0);
    run(16'h0040, 16'h0080, 1'b0, 5'h1f, 10'h3ff, 1'b0);
    run(16'h0080, 16'h0040, 1'b0, 5'h1f, 10'h03f, 1'b1);
    run(16'h0080, 16'h0040, 1'b0, 5'h1f, 10'h040, 1'b0);
    run(16'h0080, 16'h0040, 1'b0, 5'h1f, 10'h080, 1'b0);
    run(16'h0080, 16'h0040, 1'b0, 5'h1f, 10'h081, 1'b1);
    run(16'h1000, 16'h2000, 1'b1, 5'h1f, 10'h041, 1'b1);
    run(16'h1000, 16'h2000, 1'b1, 5'h1f, 10'h040, 1'b0);
    run(16'hffff, 16'h0040, 1'b0, 5'h00, 10'h3ff, 1'b0);
    run(16'hffff, 16'h0040, 1'b0, 5'h00, 10'h000, 1'b1);
    run(16'hffff, 16'h0040, 1'b0, 5'h1e, 10'h03f, 1'b1);
    run(16'hffff, 16'h0040, 1'b0, 5'h00, 10'h040, 1'b0);
    run(16'h0040, 16'hffff, 1'b0, 5'h00, 10'h3fe, 1'b1);
    run(16'h0040, 16'hffff, 1'b0, 5'h00, 10'h3ff, 1'b0);
    run(16'h0040, 16'hffff, 1'b0, 5'h00, 10'h041, 1'b1);
    run(16'hffc0, 16'h1000, 1'b1, 5'h00, 10'h000, 1'b1);
    // A strobe too soon after the last one must be dropped whole. Its code
    // would match, so a wrong acceptance shows in the flag and the result.
    wr(8'he8, 8'h00);
    conv(10'h001, 1'b1);
    `CHK(windowMatchFlag, 1'b0)
    rd(8'hbd, 8'h00);
    // The flag holds through a miss and a write of one; zero clears it.
    conv(10'h000, 1'b0);
    `CHK(windowMatchFlag, 1'b1)
    conv(10'h3fe, 1'b0);
    `CHK(windowMatchFlag, 1'b1)
    wr(8'he8, 8'hff);
    rd(8'he8, 8'h08);
    wr(8'he8, 8'h00);
    rd(8'he8, 8'h00);
    // The spacing scales with the divider: at zero ten cycles suffice.
    sarDivider = 5'h00;
    conv(10'h002, 1'b1);
    `CHK(windowMatchFlag, 1'b1)
    rd(8'hbd, 8'h80);
    // A reset in mid-run clears the flag, the result and the limits.
    sys_rst = 1'b1;
    @(negedge core_clk);
    sys_rst = 1'b0;
    `CHK(windowMatchFlag, 1'b0)
    rd(8'hbd, 8'h00);
    rd(8'hc4, 8'h00);
    results();
  end
endmodule
